// >>> slc_pkg.sv
// shared constants and types for the sleep controller
`default_nettype none
package slc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_SLEEP_CONTROL_IDX     = 8'h00;
  localparam logic [7:0] REG_REGULATOR_CONTROL_IDX = 8'h01;
  localparam logic [7:0] REG_WAKE_STATUS_IDX       = 8'h02;
  localparam logic [7:0] REG_GUARD_IDX             = 8'h03;
  // field positions
  localparam int SLEEP_EN_BIT   = 0;
  localparam int SLEEP_MODE_SELECT_LSB      = 1;
  localparam int REGULATOR_DRIVE_SELECT_LSB      = 0;
  localparam int HTLC_BIT       = 4;
  // reset values
  localparam logic [7:0] SLEEP_CONTROL_RST     = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_RST = 8'h00;
  // field codes
  localparam logic [2:0] SLEEP_MODE_SELECT_IDLE    = 3'h0;
  localparam logic [2:0] SLEEP_MODE_SELECT_STANDBY = 3'h1;
  localparam logic [2:0] SLEEP_MODE_SELECT_PDOWN   = 3'h2;
  localparam logic [2:0] REGULATOR_DRIVE_SELECT_AUTO    = 3'h0;
  localparam logic [2:0] REGULATOR_DRIVE_SELECT_FULL    = 3'h1;
  // unlock key and window (key value arbitrary)
  localparam logic [7:0] IO_REGISTER_KEY  = 8'hd8;
  localparam logic [2:0] GUARD_WINDOW_CYC = 3'h4;
  // wake-up delay in peripheral clock cycles
  localparam logic [2:0] WAKE_CYCLES = 3'h6;
  // wake source bit positions on the source vector
  localparam int SRC_PIN     = 0;
  localparam int SRC_VLM     = 1;
  localparam int SRC_MULTI_VOLTAGE_IO    = 2;
  localparam int SRC_RTC     = 3;
  localparam int SRC_PIT     = 4;
  localparam int SRC_TWI_AM  = 5;
  localparam int SRC_CCL     = 6;
  localparam int SRC_USART   = 7;
  localparam int SRC_ADC     = 8;
  localparam int SRC_TIMER   = 9;
  localparam int SRC_AC_ZCD  = 10;
  localparam int SRC_OTHER   = 11;
  localparam int SRC_COUNT   = 12;
  typedef enum logic [2:0] {
    SLC_ACTIVE,
    SLC_SLEEP,
    SLC_START,
    SLC_COUNT,
    SLC_BOD_WAIT
  } slc_state_e;
endpackage : slc_pkg
`default_nettype wire

// >>> slc_wake_filter.sv
// decides which pending interrupts may wake the core in the current mode
`default_nettype none
module slc_wake_filter (
  input  wire logic [2:0]                   mode_i,
  input  wire logic                         leak_cut_i,
  input  wire logic                         rtc_run_stdby_i,
  input  wire logic                         adc_run_stdby_i,
  input  wire logic                         lut_async_i,
  input  wire logic [slc_pkg::SRC_COUNT-1:0] irq_i,
  output logic                              wake_o
);
  logic [slc_pkg::SRC_COUNT-1:0] allow;

  // per-mode allow mask
  always_comb begin
    allow = '0;
    case (mode_i)
      slc_pkg::SLEEP_MODE_SELECT_IDLE: begin
        // every source, timers and comparators too, may end idle
        allow = '1;
      end
      slc_pkg::SLEEP_MODE_SELECT_STANDBY: begin
        allow[slc_pkg::SRC_PIN]    = 1'b1;
        allow[slc_pkg::SRC_VLM]    = 1'b1;
        allow[slc_pkg::SRC_MULTI_VOLTAGE_IO]   = 1'b1;
        allow[slc_pkg::SRC_RTC]    = rtc_run_stdby_i;
        allow[slc_pkg::SRC_PIT]    = rtc_run_stdby_i;
        allow[slc_pkg::SRC_TWI_AM] = 1'b1;
        allow[slc_pkg::SRC_CCL]    = 1'b1;
        allow[slc_pkg::SRC_USART]  = 1'b1;
        allow[slc_pkg::SRC_ADC]    = adc_run_stdby_i;
      end
      slc_pkg::SLEEP_MODE_SELECT_PDOWN: begin
        // pin wakes only with asynchronous sensing, which software sets up
        allow[slc_pkg::SRC_PIN]    = 1'b1;
        allow[slc_pkg::SRC_VLM]    = 1'b1;
        allow[slc_pkg::SRC_MULTI_VOLTAGE_IO]   = 1'b1;
        allow[slc_pkg::SRC_PIT]    = 1'b1;
        allow[slc_pkg::SRC_TWI_AM] = ~leak_cut_i;
        allow[slc_pkg::SRC_CCL]    = ~leak_cut_i & lut_async_i;
      end
      default: allow = '0;  // reserved codes never wake
    endcase
  end

  assign wake_o = |(allow & irq_i);
endmodule : slc_wake_filter
`default_nettype wire

// >>> slc_sleep_controller.sv
// sleep controller: registers, sleep sequencing and wake-up timing
// Behaviour
// - wake-up waits six peripheral clocks plus oscillator and regulator start-up when off
// - idle keeps main clock running; wake-up is only six cycles
// - standby and power-down wake add oscillator and regulator start-up to six cycles
// - standby stops main clock unless a peripheral needs it running
// - power-down runs only slow oscillator and timer if detector, watchdog or timer use them
// - with detector-wait option, wake extends until brown-out detector is ready
// - sleep controller runs normally during run-time debugging
// - debug break during sleep wakes the device to active without interrupts
// - protected write without correct unlock is ignored
// - regulator control is guarded and unlocked with the io register key
// - standby wake sources listed; converter only with run-in-standby
// - real-time clock wakes standby only with run-in-standby; power-down only timer
// - leakage cut in power-down disables address-match and logic-cell wake
// - logic cell wakes power-down only with asynchronous lookup-table path
// - timers and comparators never wake standby or power-down; others idle only
// - sleep mode field: 0 idle, 1 standby, 2 power-down, rest reserved
// - regulator drive field: 0 automatic saving, 1 full drive
// - leakage cut acts only in automatic drive and power-down sleep
//
// Implementation choice: the Wishbone slave port.
`default_nettype none
module slc_sleep_controller #(
  parameter int unsigned ADDR_W = 4
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // classic wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [ADDR_W-1:0]             wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               wb_err_o,
  // cpu side
  input  wire logic                          sleep_instr_i,
  input  wire logic                          debug_break_i,
  input  wire logic [slc_pkg::SRC_COUNT-1:0] irq_i,
  // peripheral configuration
  input  wire logic                          rtc_run_stdby_i,
  input  wire logic                          adc_run_stdby_i,
  input  wire logic                          lut_async_i,
  input  wire logic                          main_clk_needed_i,
  input  wire logic                          slow_clk_needed_i,
  input  wire logic                          bod_wait_fuse_i,
  input  wire logic                          bod_ready_i,
  input  wire logic                          osc_ready_i,
  input  wire logic                          reg_ready_i,
  // power and clock controls
  output logic                               cpu_halt_o,
  output logic                               main_clk_en_o,
  output logic                               slow_clk_en_o,
  output logic                               regulator_low_o,
  output logic                               leak_cut_o,
  output logic                               regulator_full_o,
  output logic [1:0]                         sleep_state_o
);

  typedef struct packed {
    logic [7:0]           sleep_ctrl;
    logic [7:0]           reg_ctrl;
    logic [2:0]           guard_cnt;
    slc_pkg::slc_state_e  state;
    logic [2:0]           mode;
    logic                 osc_off;
    logic                 reg_off;
    logic [2:0]           wake_cnt;
    logic                 woke_by_break;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 err;
  } slc_state_s;

  slc_state_s q, d;
  logic       wake_req;
  logic [2:0] cur_mode;
  logic       leak_eff;

  // register index from the byte address
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = 8'(a >> 2);
  endfunction : reg_index

  assign cur_mode = q.mode;
  // leakage cut only in automatic drive and power-down sleep
  assign leak_eff = q.reg_ctrl[slc_pkg::HTLC_BIT]
                    & (q.reg_ctrl[2:0] == slc_pkg::REGULATOR_DRIVE_SELECT_AUTO)
                    & (q.mode == slc_pkg::SLEEP_MODE_SELECT_PDOWN)
                    & (q.state != slc_pkg::SLC_ACTIVE);

  slc_wake_filter u_filter (
    .mode_i          (cur_mode),
    .leak_cut_i      (leak_eff),
    .rtc_run_stdby_i (rtc_run_stdby_i),
    .adc_run_stdby_i (adc_run_stdby_i),
    .lut_async_i     (lut_async_i),
    .irq_i           (irq_i),
    .wake_o          (wake_req)
  );

  // next-state logic: bus, guard and sequencer
  always_comb begin
    logic       req;
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wdata;
    req   = 1'b0;
    wr    = 1'b0;
    idx   = 8'h00;
    wdata = 8'h00;
    d     = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    req   = wb_cyc_i & wb_stb_i & ~q.ack & ~q.err;
    wr    = req & wb_we_i & wb_sel_i[0];
    idx   = reg_index(wb_adr_i);
    wdata = wb_dat_i[7:0];

    // guard window counts down after a key write
    if (q.guard_cnt != 3'h0) begin
      d.guard_cnt = q.guard_cnt - 3'h1;
    end

    if (req) begin
      d.rdata = 32'h0;
      case (idx)
        slc_pkg::REG_SLEEP_CONTROL_IDX: begin
          d.ack   = 1'b1;
          d.rdata = {24'h0, q.sleep_ctrl};
          if (wr) begin
            d.sleep_ctrl = {4'h0, wdata[3:0]};
          end
        end
        slc_pkg::REG_REGULATOR_CONTROL_IDX: begin
          d.ack   = 1'b1;
          d.rdata = {24'h0, q.reg_ctrl};
          // unguarded writes leave it unchanged
          if (wr && q.guard_cnt != 3'h0) begin
            d.reg_ctrl  = {3'h0, wdata[4], 1'b0, wdata[2:0]};
            d.guard_cnt = 3'h0;
          end
        end
        slc_pkg::REG_WAKE_STATUS_IDX: begin
          d.ack   = 1'b1;
          d.rdata = {27'h0, q.woke_by_break, 1'b0, 3'(q.state)};
        end
        slc_pkg::REG_GUARD_IDX: begin
          d.ack   = 1'b1;
          d.rdata = {29'h0, q.guard_cnt};
          if (wr && wdata == slc_pkg::IO_REGISTER_KEY) begin
            d.guard_cnt = slc_pkg::GUARD_WINDOW_CYC;
          end
        end
        default: d.err = 1'b1;  // unmapped address
      endcase
    end

    // sleep sequencer; debug only matters via break events
    case (q.state)
      slc_pkg::SLC_ACTIVE: begin
        // entry needs enable set and a known mode
        if (sleep_instr_i && q.sleep_ctrl[slc_pkg::SLEEP_EN_BIT]
            && q.sleep_ctrl[3:1] <= slc_pkg::SLEEP_MODE_SELECT_PDOWN) begin
          d.mode          = q.sleep_ctrl[3:1];
          d.state         = slc_pkg::SLC_SLEEP;
          d.woke_by_break = 1'b0;
          d.osc_off = (q.sleep_ctrl[3:1] != slc_pkg::SLEEP_MODE_SELECT_IDLE);
          d.reg_off = (q.sleep_ctrl[3:1] != slc_pkg::SLEEP_MODE_SELECT_IDLE)
                      && (q.reg_ctrl[2:0] == slc_pkg::REGULATOR_DRIVE_SELECT_AUTO);
        end
      end
      slc_pkg::SLC_SLEEP: begin
        if (wake_req || debug_break_i) begin
          d.woke_by_break = debug_break_i & ~wake_req;
          d.state         = slc_pkg::SLC_START;
        end
      end
      slc_pkg::SLC_START: begin
        // wait oscillator and regulator, then count
        if ((!q.osc_off || osc_ready_i) && (!q.reg_off || reg_ready_i)) begin
          d.wake_cnt = slc_pkg::WAKE_CYCLES - 3'h1;
          d.state    = slc_pkg::SLC_COUNT;
        end
      end
      slc_pkg::SLC_COUNT: begin
        if (q.wake_cnt != 3'h0) begin
          d.wake_cnt = q.wake_cnt - 3'h1;
        end else if (bod_wait_fuse_i && !bod_ready_i) begin
          d.state = slc_pkg::SLC_BOD_WAIT;
        end else begin
          d.state = slc_pkg::SLC_ACTIVE;
        end
      end
      slc_pkg::SLC_BOD_WAIT: begin
        if (bod_ready_i) begin
          d.state = slc_pkg::SLC_ACTIVE;
        end
      end
      default: d.state = slc_pkg::SLC_ACTIVE;
    endcase
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q            <= '0;
      q.sleep_ctrl <= slc_pkg::SLEEP_CONTROL_RST;
      q.reg_ctrl   <= slc_pkg::REGULATOR_CONTROL_RST;
      q.state      <= slc_pkg::SLC_ACTIVE;
    end else begin
      q <= d;
    end
  end

  // bus outputs; ack is a one-cycle pulse after the request
  assign wb_ack_o = q.ack;
  assign wb_err_o = q.err;
  assign wb_dat_o = q.rdata;

  // core halted from sleep entry until wake-up completes; no debug gating
  assign cpu_halt_o = (q.state != slc_pkg::SLC_ACTIVE);

  // main clock: idle keeps it, standby only on demand, power-down off
  always_comb begin
    main_clk_en_o = 1'b1;
    slow_clk_en_o = 1'b1;
    if (q.state == slc_pkg::SLC_SLEEP) begin
      case (q.mode)
        slc_pkg::SLEEP_MODE_SELECT_IDLE:    main_clk_en_o = 1'b1;
        slc_pkg::SLEEP_MODE_SELECT_STANDBY: main_clk_en_o = main_clk_needed_i;
        slc_pkg::SLEEP_MODE_SELECT_PDOWN: begin
          main_clk_en_o = 1'b0;
          slow_clk_en_o = slow_clk_needed_i;
        end
        default:                main_clk_en_o = 1'b1;
      endcase
    end
  end

  // regulator drops to low power in deep sleep under automatic drive
  assign regulator_low_o  = (q.state == slc_pkg::SLC_SLEEP) & q.reg_off;
  assign regulator_full_o = (q.reg_ctrl[2:0] == slc_pkg::REGULATOR_DRIVE_SELECT_FULL);
  assign leak_cut_o       = leak_eff & (q.state == slc_pkg::SLC_SLEEP);
  assign sleep_state_o    = (q.state == slc_pkg::SLC_SLEEP) ? 2'h1
                          : (q.state == slc_pkg::SLC_ACTIVE) ? 2'h0 : 2'h2;

endmodule : slc_sleep_controller
`default_nettype wire

// >>> slc_sleep_assertions.sv
// concurrent checks on the sleep controller ports
`default_nettype none
module slc_sleep_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       wb_err_o,
  input wire logic       sleep_instr_i,
  input wire logic       debug_break_i,
  input wire logic       bod_wait_fuse_i,
  input wire logic       bod_ready_i,
  input wire logic       osc_ready_i,
  input wire logic       reg_ready_i,
  input wire logic       cpu_halt_o,
  input wire logic       main_clk_en_o,
  input wire logic       regulator_low_o,
  input wire logic       regulator_full_o,
  input wire logic [1:0] sleep_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // the waking phase starts when the state code turns to waking
  sequence s_wake;
    $rose(sleep_state_o == 2'h2);
  endsequence
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  property p_resp;
    s_taken |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_resp: assert property (p_resp) else $error("bus request not answered once");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_halt_cause;
    $rose(cpu_halt_o) |-> $past(sleep_instr_i);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without sleep");
  // six counted cycles plus the start step keep the core halted
  property p_wake_hold;
    s_wake |-> (sleep_state_o == 2'h2) [*7];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake too short");
  property p_wake_done;
    s_wake |-> ##[7:60] (sleep_state_o == 2'h0);
  endproperty
  a_wake_done: assert property (p_wake_done) else $error("wake never ends");
  property p_gate;
    $fell(cpu_halt_o) |-> $past(osc_ready_i) && $past(reg_ready_i);
  endproperty
  a_gate: assert property (p_gate) else $error("run before supplies ready");
  property p_bod;
    cpu_halt_o && sleep_state_o == 2'h2 && bod_wait_fuse_i && !bod_ready_i |=> cpu_halt_o;
  endproperty
  a_bod: assert property (p_bod) else $error("ran before detector ready");
  property p_break;
    sleep_state_o == 2'h1 && debug_break_i |=> sleep_state_o == 2'h2;
  endproperty
  a_break: assert property (p_break) else $error("break did not wake");
  property p_active_clk;
    sleep_state_o == 2'h0 |-> main_clk_en_o;
  endproperty
  a_active_clk: assert property (p_active_clk) else $error("main clock off while active");
  property p_full;
    regulator_full_o |-> !regulator_low_o;
  endproperty
  a_full: assert property (p_full) else $error("full drive but regulator off");
endmodule : slc_sleep_assertions
bind slc_sleep_controller slc_sleep_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .sleep_instr_i(sleep_instr_i), .debug_break_i(debug_break_i),
  .bod_wait_fuse_i(bod_wait_fuse_i), .bod_ready_i(bod_ready_i), .osc_ready_i(osc_ready_i),
  .reg_ready_i(reg_ready_i), .cpu_halt_o(cpu_halt_o), .main_clk_en_o(main_clk_en_o),
  .regulator_low_o(regulator_low_o), .regulator_full_o(regulator_full_o),
  .sleep_state_o(sleep_state_o));
`default_nettype wire

// >>> slc_far_model.sv
// behavioural far side: oscillator, regulator and detector readiness
`default_nettype none
module slc_far_model #(
  parameter int OSC_DLY = 3,
  parameter int REG_DLY = 2,
  parameter int BOD_DLY = 12
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       main_clk_en_i,
  input  wire logic       regulator_low_i,
  input  wire logic [1:0] sleep_state_i,
  output logic            osc_ready_o,
  output logic            reg_ready_o,
  output logic            bod_ready_o
);
  int osc_q, reg_q, bod_q;
  // a stopped source loses readiness at once, so a fast wake is never faked
  always_ff @(posedge clk_i) begin
    osc_q <= (rst_i || !main_clk_en_i) ? 0 : osc_q + int'(osc_q < 15);
    reg_q <= (rst_i || regulator_low_i) ? 0 : reg_q + int'(reg_q < 15);
    bod_q <= (rst_i || sleep_state_i == 2'h1) ? 0 : bod_q + int'(bod_q < 31);
  end
  assign osc_ready_o = main_clk_en_i && osc_q >= OSC_DLY;
  assign reg_ready_o = !regulator_low_i && reg_q >= REG_DLY;
  assign bod_ready_o = bod_q >= BOD_DLY;
endmodule : slc_far_model
`default_nettype wire

// >>> slc_sleep_controller_tb.sv
// self-checking bench for the sleep controller
`default_nettype none
module slc_sleep_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, slp, brk, rtc_rs, adc_rs, lut, clk_nd, slow_nd, fuse;
  logic        ack, err, halt, mclk, sclk, rlow, leak_o, rfull, osc_rdy, reg_rdy, bod_rdy;
  logic [4:0]  adr;
  logic [31:0] dat, rdat;
  logic [11:0] irq;
  logic [1:0]  st;
  logic [9:0]  notes [$];
  int          mismatches, checks_done, n;
  slc_sleep_controller #(.ADDR_W(5)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .sleep_instr_i(slp),
    .debug_break_i(brk), .irq_i(irq), .rtc_run_stdby_i(rtc_rs), .adc_run_stdby_i(adc_rs),
    .lut_async_i(lut), .main_clk_needed_i(clk_nd), .slow_clk_needed_i(slow_nd),
    .bod_wait_fuse_i(fuse), .bod_ready_i(bod_rdy), .osc_ready_i(osc_rdy),
    .reg_ready_i(reg_rdy), .cpu_halt_o(halt), .main_clk_en_o(mclk), .slow_clk_en_o(sclk),
    .regulator_low_o(rlow), .leak_cut_o(leak_o), .regulator_full_o(rfull),
    .sleep_state_o(st));
  slc_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .main_clk_en_i(mclk),
    .regulator_low_i(rlow), .sleep_state_i(st), .osc_ready_o(osc_rdy),
    .reg_ready_o(reg_rdy), .bod_ready_o(bod_rdy));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check
  // one classic cycle; note = {compare data, expect err, data}
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [9:0] nt);
    notes.push_back(nt);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
    {cyc, stb} <= 2'b00;
  endtask : bus
  // answers are matched in order against the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1 || err === 1'b1) begin
      logic [9:0] nt;
      nt = notes.pop_front();
      check(err === nt[8] && (!nt[9] || rdat[7:0] === nt[7:0]), "bus answer");
    end
  end
  task automatic wake_wait();
    n = 0;
    while (halt === 1'b1 && n < 60) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : wake_wait
  task automatic sleep_try(input logic [7:0] d, input logic exp);
    bus(1'b1, 5'h00, d, 10'h000);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check(halt === exp, "sleep entry");
  endtask : sleep_try
  // cfg = {rtc run, adc run, lut async, leak cut}
  task automatic run_case(input logic [2:0] m, input int s, input logic [3:0] cfg, input logic wk);
    bus(1'b1, 5'h0c, 8'hd8, 10'h000);
    bus(1'b1, 5'h04, {3'h0, cfg[0], 4'h0}, 10'h000);
    {rtc_rs, adc_rs, lut, clk_nd, slow_nd} <= {cfg[3:1], 2'($urandom)};
    sleep_try({4'h0, m, 1'b1}, 1'b1);
    check(mclk === (m == 0 || (m == 1 && clk_nd)), "main clock in sleep");
    check(leak_o === (m == 2 && cfg[0]), "leak cut");
    if (m == 2) check(sclk === slow_nd, "slow clock");
    repeat ($urandom_range(4, 1)) @(posedge clk_i);
    irq[s] <= 1'b1;
    wake_wait();
    if (wk) check((m == 0 && !fuse) ? n == 8 : n > 8, "wake time");
    else begin
      check(n == 60, "stray wake");
      @(posedge clk_i);
      {irq, brk} <= {12'h000, 1'b1};
      @(posedge clk_i);
      brk <= 1'b0;
      wake_wait();
      bus(1'b0, 5'h08, 8'h00, {2'b10, 8'h10});
    end
    @(posedge clk_i);
    irq <= '0;
  endtask : run_case
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
  initial begin
    {cyc, stb, we, adr, dat, slp, brk, irq, rtc_rs, adc_rs, lut, clk_nd, slow_nd, fuse} <= '0;
    rst_i <= 1'b1;
    void'($urandom(32'h03e2));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 5'h00, 8'h00, {2'b10, 8'h00});
    bus(1'b0, 5'h04, 8'h00, {2'b10, 8'h00});
    bus(1'b1, 5'h10, 8'h55, 10'h100);
    bus(1'b1, 5'h04, 8'h01, 10'h000);
    bus(1'b0, 5'h04, 8'h00, {2'b10, 8'h00});
    bus(1'b1, 5'h0c, 8'hd8, 10'h000);
    bus(1'b1, 5'h04, 8'h01, 10'h000);
    bus(1'b0, 5'h04, 8'h00, {2'b10, 8'h01});
    check(rfull === 1'b1 && rlow === 1'b0, "full drive");
    sleep_try(8'h07, 1'b0);
    sleep_try(8'h02, 1'b0);
    run_case(3'h0, slc_pkg::SRC_TIMER, 4'h0, 1'b1);
    run_case(3'h0, slc_pkg::SRC_OTHER, 4'h0, 1'b1);
    run_case(3'h1, slc_pkg::SRC_TIMER, 4'h0, 1'b0);
    run_case(3'h1, slc_pkg::SRC_USART, 4'h0, 1'b1);
    run_case(3'h1, slc_pkg::SRC_ADC, 4'h0, 1'b0);
    run_case(3'h1, slc_pkg::SRC_ADC, 4'h4, 1'b1);
    run_case(3'h1, slc_pkg::SRC_RTC, 4'h0, 1'b0);
    run_case(3'h1, slc_pkg::SRC_RTC, 4'h8, 1'b1);
    run_case(3'h2, slc_pkg::SRC_RTC, 4'h8, 1'b0);
    run_case(3'h2, slc_pkg::SRC_PIT, 4'h0, 1'b1);
    run_case(3'h2, slc_pkg::SRC_TWI_AM, 4'h1, 1'b0);
    run_case(3'h2, slc_pkg::SRC_TWI_AM, 4'h0, 1'b1);
    run_case(3'h2, slc_pkg::SRC_CCL, 4'h0, 1'b0);
    run_case(3'h2, slc_pkg::SRC_CCL, 4'h2, 1'b1);
    run_case(3'h2, slc_pkg::SRC_AC_ZCD, 4'h0, 1'b0);
    fuse <= 1'b1;
    run_case(3'h0, slc_pkg::SRC_PIN, 4'h0, 1'b1);
    give_verdict();
  end
endmodule : slc_sleep_controller_tb
`default_nettype wire
